// ### verilog/sar_accum_consts.vh
`ifndef SAR_ACCUM_CONSTS_VH
`define SAR_ACCUM_CONSTS_VH
// converter resolution variants
`define RES_WIDE 14
`define RES_NARROW 12
// conversion input width (raw front-end result, signed)
`define RAW_W 16
// accumulated word width ceiling and max count
`define SUM_W 24
`define CNT_W 11
`define MAX_CONV 11'h400
`define CNT_ONE 11'h001
// host quiet gap in ns and in ref_clk cycles (25 MHz, 40 ns)
`define QUIET_GAP_NS 10
`define CLK_PERIOD_NS 40
`define QUIET_GAP_CYC (((`QUIET_GAP_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
// buffer shape
`define FIFO_W 29
`define FIFO_D 4
`define FIFO_AW 2
`endif

// ### verilog/result_fifo.v
`timescale 1ns/100ps
module result_fifo #(
    parameter WIDTH = 29,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire ref_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] fill_r;
    wire push;
    wire pop;

    assign in_ready = (fill_r != DEPTH[AW:0]);
    assign out_valid = (fill_r != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            fill_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                fill_r <= fill_r + 1'b1;
            end else if (pop & ~push) begin
                fill_r <= fill_r - 1'b1;
            end
        end
    end
endmodule

// ### verilog/sar_adc_output_accumulator.v
`timescale 1ns/100ps
`include "sar_accum_consts.vh"
// Notes on behaviour
// - each result is an unsigned straight-binary code, 14 bits wide or 12 bits on the narrow variant.
// - results clamp to all ones above full scale less one step and to all zeros at or below zero.
// - a half-reference input gives a code with only the top bit set.
// - one code step is the reference divided by two to the power of the resolution.
// - each unread conversion is added into a running sum, for up to 1024 conversions.
// - any serial clock pulse before the next start discards the unread result and returns to single samples.
// - on the wide variant the word grows with the count: 14 bits for 1 up to 24 bits for 513-1024.
// - the accumulator needs no configuration and is steered only by whether readout clocks occur.
// - a start strobe rising edge freezes the input and starts a conversion that always completes.
// - the result shifts out top bit first while the next acquisition is running.
// - the link is mode 0, clock idle low, with data changed on each falling serial clock edge.
module sar_adc_output_accumulator (
    input wire ref_clk,
    input wire rst_n,
    input wire narrow_variant,
    input wire conversion_start_strobe,
    input wire serial_clk,
    input wire raw_valid,
    input wire [15:0] raw_sample,
    output reg sample_hold,
    output reg conv_request,
    output reg serial_data_out,
    output reg serial_data_oe,
    output reg [4:0] word_bits,
    output reg overflow_drop
);
    localparam ST_ACQ = 3'h1;
    localparam ST_CONV = 3'h2;
    localparam ST_DONE = 3'h4;

    reg [2:0] cnv_sync_r;
    reg [2:0] sck_sync_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [`SUM_W-1:0] sum_r;
    reg [`CNT_W-1:0] count_r;
    reg [`SUM_W-1:0] shift_r;
    reg [4:0] bits_left_r;
    reg clocked_r;
    reg pending_r;
    reg narrow_r;
    reg [1:0] strap_sync_r;
    reg [1:0] strap_wait_r;
    wire cnv_rise;
    wire cnv_fall;
    wire sck_rise;
    wire sck_fall;
    wire [13:0] code;
    wire fifo_valid;
    wire fifo_ready;
    wire [`FIFO_W-1:0] fifo_data;
    wire [`FIFO_W-1:0] fifo_in;

    // ceiling of log2 for 1..1024, used for both variants
    function [4:0] clog2_cnt;
        input [`CNT_W-1:0] n;
        integer k;
        begin
            clog2_cnt = 5'h00;
            for (k = 0; k < 11; k = k + 1) begin
                if ((11'h001 << k) < n) begin
                    clog2_cnt = k[4:0] + 5'h01;
                end
            end
        end
    endfunction

    // clamp a signed raw front-end value to the variant code range
    function [13:0] clamp_code;
        input [15:0] raw;
        input nar;
        reg [13:0] top;
        begin
            top = nar ? 14'h0FFF : 14'h3FFF;
            if (raw[15]) begin
                clamp_code = 14'h0000;
            end else if (raw[14:0] > {1'b0, top}) begin
                clamp_code = top;
            end else begin
                clamp_code = raw[13:0];
            end
        end
    endfunction

    // first stage only feeds the second, so edge detectors look past the first flop
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnv_sync_r <= 3'h0;
            sck_sync_r <= 3'h0;
        end else begin
            cnv_sync_r <= {cnv_sync_r[1:0], conversion_start_strobe};
            sck_sync_r <= {sck_sync_r[1:0], serial_clk};
        end
    end
    assign cnv_rise = cnv_sync_r[1] & ~cnv_sync_r[2];
    assign cnv_fall = ~cnv_sync_r[1] & cnv_sync_r[2];
    assign sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
    assign sck_fall = ~sck_sync_r[1] & sck_sync_r[2];

    // variant strap is a pin: two flops first, then caught once on the third edge and held
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            narrow_r <= 1'b0;
            strap_sync_r <= 2'h0;
            strap_wait_r <= 2'h0;
        end else begin
            strap_sync_r <= {strap_sync_r[0], narrow_variant};
            if (strap_wait_r != 2'h3) begin
                strap_wait_r <= strap_wait_r + 2'h1;
            end
            if (strap_wait_r == 2'h2) begin
                narrow_r <= strap_sync_r[1];
            end
        end
    end

    assign code = clamp_code(raw_sample, narrow_r);
    assign fifo_in = {code, raw_sample[15], 14'h0000};

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_ACQ: begin
                if (cnv_rise) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                // strobe activity is ignored until the result arrives
                if (fifo_valid) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = ST_ACQ;
            end
            default: begin
                state_nxt = ST_ACQ;
            end
        endcase
    end

    assign fifo_ready = (state_r == ST_CONV);

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_ACQ;
            sample_hold <= 1'b0;
            conv_request <= 1'b0;
            sum_r <= {`SUM_W{1'b0}};
            count_r <= {`CNT_W{1'b0}};
            shift_r <= {`SUM_W{1'b0}};
            bits_left_r <= 5'h00;
            clocked_r <= 1'b0;
            pending_r <= 1'b0;
            serial_data_out <= 1'b0;
            serial_data_oe <= 1'b0;
            word_bits <= 5'h00;
            overflow_drop <= 1'b0;
        end else begin
            state_r <= state_nxt;
            conv_request <= (state_r == ST_ACQ) & cnv_rise;
            overflow_drop <= 1'b0;
            if (state_r == ST_ACQ && cnv_rise) begin
                sample_hold <= 1'b1;
                serial_data_oe <= 1'b0;
                bits_left_r <= 5'h00;
                // any serial clock since the last result drops the unread sum
                // a serial clock landing on the start edge itself still counts as a discard
                if (clocked_r || sck_rise || !pending_r) begin
                    count_r <= {`CNT_W{1'b0}};
                    sum_r <= {`SUM_W{1'b0}};
                end
                clocked_r <= 1'b0;
            end else if (state_r == ST_CONV && fifo_valid) begin
                sample_hold <= 1'b0;
                pending_r <= 1'b1;
                if (count_r == `MAX_CONV) begin
                    // beyond 1024 a new single-sample run starts to keep the word at 24 bits
                    sum_r <= {10'h000, fifo_data[28:15]};
                    count_r <= `CNT_ONE;
                    overflow_drop <= 1'b1;
                end else begin
                    sum_r <= sum_r + {10'h000, fifo_data[28:15]};
                    count_r <= count_r + `CNT_ONE;
                end
            end else if (state_r == ST_DONE) begin
                // word width tracks the count held in the sum
                word_bits <= (narrow_r ? 5'h0C : 5'h0E) + clog2_cnt(count_r);
                shift_r <= sum_r;
                bits_left_r <= (narrow_r ? 5'h0C : 5'h0E) + clog2_cnt(count_r);
            end else if (state_r == ST_ACQ) begin
                if (cnv_fall && bits_left_r != 5'h00) begin
                    serial_data_oe <= 1'b1;
                    serial_data_out <= shift_r[bits_left_r - 5'h01];
                end
                if (sck_rise) begin
                    clocked_r <= 1'b1;
                end
                if (sck_fall && serial_data_oe) begin
                    if (bits_left_r <= 5'h01) begin
                        serial_data_oe <= 1'b0;
                        bits_left_r <= 5'h00;
                        pending_r <= 1'b0;
                    end else begin
                        bits_left_r <= bits_left_r - 5'h01;
                        serial_data_out <= shift_r[bits_left_r - 5'h02];
                    end
                end
            end
        end
    end

    result_fifo #(
        .WIDTH(`FIFO_W),
        .DEPTH(`FIFO_D),
        .AW(`FIFO_AW)
    ) u_result_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(raw_valid),
        .in_ready(),
        .in_data(fifo_in),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );
endmodule

// ### testbench/sar_accum_props.sv
`timescale 1ns/100ps
module sar_accum_props (
    input wire ref_clk,
    input wire rst_n,
    input wire conversion_start_strobe,
    input wire serial_clk,
    input wire sample_hold,
    input wire conv_request,
    input wire serial_data_out,
    input wire serial_data_oe,
    input wire [4:0] word_bits,
    input wire overflow_drop
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence
    a_req_pulse: assert property (conv_request |-> s_pulse(conv_request))
        else $error("start pulse longer than one cycle");
    a_req_cause: assert property (conv_request |-> $past(conversion_start_strobe, 2))
        else $error("conversion without start strobe");
    a_hold_start: assert property ($rose(sample_hold) |-> conv_request)
        else $error("hold rose without start");
    a_oe_closed: assert property (conv_request |=> !serial_data_oe)
        else $error("output driven during conversion");
    a_width_range: assert property (serial_data_oe |-> word_bits >= 5'h0C && word_bits <= 5'h18)
        else $error("word length out of range");
    a_width_hold: assert property (serial_data_oe ##1 serial_data_oe |-> $stable(word_bits))
        else $error("word length moved during readout");
    a_mode_zero: assert property (serial_data_oe && $changed(serial_data_out) |-> !serial_clk)
        else $error("data changed while serial clock high");
    a_drop_pulse: assert property (overflow_drop |-> s_pulse(overflow_drop))
        else $error("overflow pulse longer than one cycle");
endmodule
bind sar_adc_output_accumulator sar_accum_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .conversion_start_strobe(conversion_start_strobe), .serial_clk(serial_clk),
    .sample_hold(sample_hold), .conv_request(conv_request), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .word_bits(word_bits), .overflow_drop(overflow_drop));

// ### testbench/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
    input wire ref_clk,
    input wire serial_data_out,
    input wire serial_data_oe,
    output reg conversion_start_strobe,
    output reg serial_clk
);
    initial begin
        conversion_start_strobe = 1'b0;
        serial_clk = 1'b0;
    end
    task wait_clk(input integer n);
        repeat (n) @(negedge ref_clk);
    endtask
    task start(input logic lvl);
        if (lvl)
            wait_clk(3);
        conversion_start_strobe = lvl;
    endtask
    // 320 ns serial period; a released line reads as x so it never passes for data
    task read(input integer n, output logic [23:0] word);
        integer i;
        word = 24'h000000;
        wait_clk(6);
        for (i = 0; i < n; i = i + 1) begin
            word = {word[22:0], serial_data_oe ? serial_data_out : 1'bx};
            serial_clk = 1'b1;
            wait_clk(4);
            serial_clk = 1'b0;
            wait_clk(4);
        end
    endtask
endmodule

// ### testbench/sar_adc_output_accumulator_tb.sv
`timescale 1ns/100ps
module sar_adc_output_accumulator_tb;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    reg narrow_variant = 1'b0;
    reg raw_valid = 1'b0;
    reg [15:0] raw_sample = 16'h0000;
    wire strobe, sclk, sdo, oe, hold, req, drop;
    wire [4:0] word_bits;
    integer n_mismatch = 0;
    integer checked = 0;
    integer drops = 0;
    integer k;
    reg [23:0] word;
    initial forever #20 ref_clk = ~ref_clk;
    sar_adc_output_accumulator dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .narrow_variant(narrow_variant), .conversion_start_strobe(strobe),
        .serial_clk(sclk), .raw_valid(raw_valid), .raw_sample(raw_sample),
        .sample_hold(hold), .conv_request(req), .serial_data_out(sdo),
        .serial_data_oe(oe), .word_bits(word_bits), .overflow_drop(drop));
    spi_host_model host (.ref_clk(ref_clk), .serial_data_out(sdo),
        .serial_data_oe(oe), .conversion_start_strobe(strobe), .serial_clk(sclk));
    always @(posedge ref_clk) if (drop === 1'b1) drops = drops + 1;
    task check(input logic [23:0] seen, input logic [23:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task do_reset(input logic nar);
        rst_n = 1'b0;
        narrow_variant = nar;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask
    // one start, core result, open; the strobe stays high until the result has landed
    task convert(input logic [15:0] raw);
        integer t;
        host.start(1'b1);
        t = 0;
        while (req !== 1'b1 && t < 20) begin
            @(negedge ref_clk);
            t = t + 1;
        end
        if (t == 20) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
        check({23'h000000, hold}, 24'h000001);
        raw_sample = raw;
        raw_valid = 1'b1;
        @(negedge ref_clk);
        raw_valid = 1'b0;
        repeat (4) @(negedge ref_clk);
        check({23'h000000, hold}, 24'h000000);
        host.start(1'b0);
    endtask
    task read_check(input integer n, input logic [23:0] exp);
        repeat (4) @(negedge ref_clk);
        check({19'h00000, word_bits}, n[23:0]);
        host.read(n, word);
        check(word, exp);
        check({23'h000000, oe}, 24'h000000);
    endtask
    task t_single;
        convert(16'h2000);
        read_check(14, 24'h002000);
        convert(16'hFFFB);
        read_check(14, 24'h000000);
        convert(16'h4E20);
        read_check(14, 24'h003FFF);
        convert(16'h0001);
        read_check(14, 24'h000001);
        $display("single samples done");
    endtask
    task t_accum;
        convert(16'h3FFF);
        convert(16'h3FFF);
        convert(16'h0064);
        read_check(16, 24'h008062);
        convert(16'h01F4);
        host.read(1, word);
        convert(16'h0007);
        read_check(14, 24'h000007);
        $display("accumulate and discard done");
    endtask
    task t_long;
        for (k = 0; k < 1024; k = k + 1)
            convert(16'h3FFF);
        read_check(24, 24'hFFFC00);
        drops = 0;
        for (k = 0; k < 1025; k = k + 1)
            convert(16'h0002);
        check(drops[23:0], 24'h000001);
        read_check(14, 24'h000002);
        $display("long run done");
    endtask
    task t_narrow;
        do_reset(1'b1);
        convert(16'h1388);
        read_check(12, 24'h000FFF);
        convert(16'h0800);
        convert(16'h0800);
        read_check(13, 24'h001000);
        convert(16'h0800);
        read_check(12, 24'h000800);
        $display("narrow variant done");
    endtask
    initial begin
        do_reset(1'b0);
        t_single;
        t_accum;
        t_long;
        t_narrow;
        complete_run;
    end
endmodule
